// ### design/lfa_pkg.sv
// Package for the literal/file ALU slice: opcode patterns, field layout,
// reset values. Assumes a 14-bit instruction word from the fetch stage.
package lfa_pkg;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int LFA_IW = 14;
  localparam int LFA_DW = 8;
  localparam int LFA_AW = 7;
  localparam int LFA_DEST_BIT = 7;
  localparam int LFA_ADDR_LSB = 0;
  localparam int LFA_LIT_LSB = 0;

  // ----------------------------------------
  // Opcode patterns, top six bits
  // ----------------------------------------
  localparam logic [5:0] LFA_OPC_ADDL = 6'h3E;
  localparam logic [5:0] LFA_MSK_ADDL = 6'h3E;
  localparam logic [5:0] LFA_OPC_ANDL = 6'h39;
  localparam logic [5:0] LFA_OPC_IORL = 6'h38;
  localparam logic [5:0] LFA_OPC_MOVL = 6'h30;
  localparam logic [5:0] LFA_MSK_MOVL = 6'h3C;
  localparam logic [5:0] LFA_OPC_ANDF = 6'h05;
  localparam logic [5:0] LFA_OPC_ADDF = 6'h07;
  localparam logic [5:0] LFA_OPC_IORF = 6'h04;
  localparam logic [5:0] LFA_MSK_FULL = 6'h3F;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] LFA_ACC_RST = 8'h00;
  localparam logic LFA_FLAG_RST = 1'b0;

  typedef enum logic [2:0] {
    LFA_NOP, LFA_ADD, LFA_AND, LFA_IOR, LFA_MOV
  } lfa_op_t;

endpackage : lfa_pkg

// ### design/lfa_adder.sv
// Eight-bit adder with carry and digit-carry outputs.
// Assumes purely combinational use inside the execute stage.
`timescale 1ns/1ps
`default_nettype none
module lfa_adder #(
  parameter int DW = 8
) (
  input wire logic [DW-1:0] a,
  input wire logic [DW-1:0] b,
  output logic [DW-1:0] sum,
  output logic carry,
  output logic digit_carry
);
  logic [DW:0] full;
  logic [4:0] low;

  // ----------------------------------------
  // Sum and carries
  // ----------------------------------------
  assign full = {1'b0, a} + {1'b0, b};
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign sum = full[DW-1:0];
  assign carry = full[DW];
  assign digit_carry = low[4];
endmodule // lfa_adder
`default_nettype wire

// ### design/lfa_alu.sv
// Execute stage for add/and/or with literal or file operand, and load of a literal.
// Assumes fetch gives one instruction per valid cycle and the register
// file returns file_rdata combinationally for file_addr in that cycle.
//
// What this block does
// - Add literal to accumulator, all flags
// - AND literal into accumulator, zero only
// - AND file with accumulator, zero only
// - Add file and accumulator, all flags
// - OR literal into accumulator, zero only
// - Load literal, flags unchanged, dont-cares any value
// - OR file with accumulator, zero only
// - Destination bit picks accumulator or file
`timescale 1ns/1ps
`default_nettype none
module lfa_alu
  import lfa_pkg::*;
#(
  parameter int IW = LFA_IW,
  parameter int DW = LFA_DW,
  parameter int AW = LFA_AW
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic instr_valid,
  input wire logic [IW-1:0] instr,
  output logic [AW-1:0] file_addr,
  input wire logic [DW-1:0] file_rdata,
  output logic file_we,
  output logic [DW-1:0] file_wdata,
  output logic [DW-1:0] acc_q,
  output logic carry_q,
  output logic digit_carry_q,
  output logic zero_q,
  output logic illegal
);
  lfa_op_t op;
  logic use_file;
  logic dest_file;
  logic flags_all;
  logic flags_zero;
  logic [DW-1:0] operand;
  logic [DW-1:0] result;
  logic [DW-1:0] sum;
  logic add_c;
  logic add_dc;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic hit(input logic [5:0] top, input logic [5:0] pat,
                               input logic [5:0] msk);
    return (top & msk) == pat;
  endfunction

  logic [5:0] top;
  assign top = instr[IW-1:IW-6];

  always_comb begin
    op = LFA_NOP;
    use_file = 1'b0;
    if (hit(top, LFA_OPC_ADDL, LFA_MSK_ADDL)) begin
      op = LFA_ADD;
    end else if (hit(top, LFA_OPC_ANDL, LFA_MSK_FULL)) begin
      op = LFA_AND;
    end else if (hit(top, LFA_OPC_IORL, LFA_MSK_FULL)) begin
      op = LFA_IOR;
    end else if (hit(top, LFA_OPC_MOVL, LFA_MSK_MOVL)) begin
      // Dont-care bits accepted in any value; assembler emits zeros
      op = LFA_MOV;
    end else if (hit(top, LFA_OPC_ANDF, LFA_MSK_FULL)) begin
      op = LFA_AND;
      use_file = 1'b1;
    end else if (hit(top, LFA_OPC_ADDF, LFA_MSK_FULL)) begin
      op = LFA_ADD;
      use_file = 1'b1;
    end else if (hit(top, LFA_OPC_IORF, LFA_MSK_FULL)) begin
      op = LFA_IOR;
      use_file = 1'b1;
    end
  end

  // ----------------------------------------
  // Operand select and result
  // ----------------------------------------
  // Address and literal both come from the low bits of the same word
  assign file_addr = instr[LFA_ADDR_LSB +: AW];
  assign operand = use_file ? file_rdata : instr[LFA_LIT_LSB +: DW];
  assign dest_file = use_file & instr[LFA_DEST_BIT];

  lfa_adder #(.DW(DW)) u_add (
    .a(acc_q),
    .b(operand),
    .sum(sum),
    .carry(add_c),
    .digit_carry(add_dc)
  );

  always_comb begin
    result = operand;
    flags_all = 1'b0;
    flags_zero = 1'b0;
    unique case (op)
      LFA_ADD: begin
        result = sum;
        flags_all = 1'b1;
      end
      LFA_AND: begin
        result = acc_q & operand;
        flags_zero = 1'b1;
      end
      LFA_IOR: begin
        result = acc_q | operand;
        flags_zero = 1'b1;
      end
      LFA_MOV: begin
        result = operand;
      end
      LFA_NOP: begin
        result = operand;
      end
    endcase
  end

  // Unknown opcodes belong to the rest of the core; flagged, no effect here
  assign illegal = instr_valid & (op == LFA_NOP);

  // ----------------------------------------
  // File write-back, same cycle
  // ----------------------------------------
  assign file_we = instr_valid & (op != LFA_NOP) & dest_file;
  assign file_wdata = result;

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      acc_q <= LFA_ACC_RST;
    end else if (instr_valid && op != LFA_NOP && !dest_file) begin
      acc_q <= result;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      zero_q <= LFA_FLAG_RST;
    end else if (instr_valid && (flags_all || flags_zero)) begin
      zero_q <= (result == '0);
    end
  end

  // Carry pair only moves on adds; logic ops keep it
  always_ff @(posedge mclk) begin
    if (srst) begin
      carry_q <= LFA_FLAG_RST;
      digit_carry_q <= LFA_FLAG_RST;
    end else if (instr_valid && flags_all) begin
      carry_q <= add_c;
      digit_carry_q <= add_dc;
    end
  end
endmodule // lfa_alu
`default_nettype wire

// ### test/lfa_file_model.sv
// Register file model: 128 bytes, read without delay
// Assumes a write on the rising edge while file_we is high
`timescale 1ns/1ps
`default_nettype none
module lfa_file_model (
  input wire logic mclk,
  input wire logic file_we,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem_q [128];
  initial for (int i = 0; i < 128; i++) mem_q[i] = 8'(i * 37);
  assign file_rdata = mem_q[file_addr];
  always @(posedge mclk) if (file_we) mem_q[file_addr] <= file_wdata;
endmodule // lfa_file_model
`default_nettype wire

// ### test/lfa_alu_chk.sv
// Port checker for the ALU slice
// Assumes one clock, bound to lfa_alu
`timescale 1ns/1ps
`default_nettype none
module lfa_alu_chk (
  input wire logic mclk, srst, instr_valid, file_we, carry_q, digit_carry_q, zero_q, illegal,
  input wire logic [13:0] instr,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_rdata, file_wdata, acc_q
);
  logic [7:0] b, r;
  logic [8:0] s;
  logic [4:0] h;
  logic alu, fw;
  assign b = instr[13] ? instr[7:0] : file_rdata;
  assign s = acc_q + b;
  assign h = acc_q[3:0] + b[3:0];
  assign r = instr[9] ? s[7:0] : instr[8] ? acc_q & b : acc_q | b;
  assign alu = instr_valid && !illegal && (instr[13:12] == 0 || instr[13:11] == 7);
  assign fw = alu && !instr[13] && instr[7];
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_acc_value: assert property (alu && !fw |=> acc_q == $past(r))
    else $error("bad acc");
  chk_zero_flag: assert property (alu |=> zero_q == ($past(r) == 0))
    else $error("bad zero");
  chk_carry_pair: assert property (alu && instr[9] |=> carry_q == $past(s[8])
    && digit_carry_q == $past(h[4])) else $error("bad carry");
  chk_logic_carry: assert property (alu && !instr[9] |=> $stable({carry_q, digit_carry_q}))
    else $error("carry moved");
  chk_file_dest: assert property (fw |-> file_we && file_wdata == r
    && file_addr == instr[6:0] ##1 $stable(acc_q)) else $error("bad write");
  chk_no_write: assert property (!fw |-> !file_we)
    else $error("stray write");
  chk_load_lit: assert property (instr_valid && instr[13:10] == 4'hC |=>
    acc_q == $past(instr[7:0]) && $stable({carry_q, digit_carry_q, zero_q})) else $error("bad load");
  chk_refused_quiet: assert property (instr_valid && illegal |=>
    $stable({acc_q, carry_q, digit_carry_q, zero_q})) else $error("refused op changed state");
endmodule // lfa_alu_chk
bind lfa_alu lfa_alu_chk i_chk (.mclk, .srst, .instr_valid, .file_we, .carry_q, .digit_carry_q,
  .zero_q, .illegal, .instr, .file_addr, .file_rdata, .file_wdata, .acc_q);
`default_nettype wire

// ### test/lfa_alu_bench.sv
// Bench for the ALU slice
// Assumes the bound checker and the register file model
`timescale 1ns/1ps
`default_nettype none
module lfa_alu_bench;
  logic mclk = 0, srst = 1, instr_valid = 0, file_we, carry_q, digit_carry_q, zero_q, c, dc, z, we;
  logic illegal, il;
  logic [13:0] instr = 0;
  logic [6:0] file_addr;
  logic [7:0] file_rdata, file_wdata, acc_q, a, b, r;
  logic [8:0] s;
  logic [7:0] sh [128];
  logic [20:0] exp_q [$], seen;
  int n_fail = 0, compares = 0;
  // Two codes outside the subset exercise the refused path
  logic [5:0] ops [11] = '{6'h3E, 6'h3F, 6'h39, 6'h38, 6'h30, 6'h33, 6'h04, 6'h05, 6'h07,
    6'h06, 6'h3C};
  lfa_alu i_dut (.mclk, .srst, .instr_valid, .instr, .file_addr, .file_rdata, .file_we,
    .file_wdata, .acc_q, .carry_q, .digit_carry_q, .zero_q, .illegal);
  lfa_file_model i_file (.mclk, .file_we, .file_addr, .file_wdata, .file_rdata);
  initial forever #10 mclk = ~mclk;
  task automatic check(input logic [20:0] got, want);
    compares++;
    if (got !== want) begin
      n_fail++;
      $display("Error result exp %h seen %h", want, got);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Prediction made at issue time, so back-to-back file reads see earlier writes
  task automatic issue(input logic [13:0] i, input logic v);
    @(posedge mclk);
    instr <= i;
    instr_valid <= v;
    b = i[13] ? i[7:0] : sh[i[6:0]];
    s = a + b;
    we = 0;
    il = 0;
    if (!v) return;
    if (i[13:10] == 4'hC) a = i[7:0];
    else if ((i[13:10] == 1 && i[9:8] != 2) || (i[13:11] == 7 && i[10] == i[9])) begin
      r = i[9] ? s[7:0] : i[8] ? a & b : a | b;
      if (i[9]) {c, dc} = {s[8], a[3:0] + b[3:0] > 15};
      z = r == 0;
      if (!i[13] && i[7]) begin
        we = 1;
        sh[i[6:0]] = r;
      end else a = r;
    end else il = 1;
    exp_q.push_back({il, we, we ? r : 8'h00, a, c, dc, z});
  endtask
  always @(posedge mclk) begin
    if (instr_valid && !srst) begin
      seen[20:11] = {illegal, file_we, file_we ? file_wdata : 8'h00};
      #1;
      seen[10:0] = {acc_q, carry_q, digit_carry_q, zero_q};
      check(seen, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h2CBC));
    for (int k = 0; k < 128; k++) sh[k] = 8'(k * 37);
    {a, c, dc, z} = 0;
    repeat (5) @(posedge mclk);
    srst <= 0;
    foreach (ops[k]) issue({ops[k], 8'hFF}, 1);
    issue(14'h0202, 1);
    issue(14'h3A0F, 1);
    repeat (300) issue({ops[$urandom_range(10)], 8'($urandom)}, $urandom_range(3) != 0);
    issue(0, 0);
    srst <= 1;
    repeat (2) @(posedge mclk);
    srst <= 0;
    {a, c, dc, z} = 0;
    issue(14'h3000, 1);
    issue(14'h3E00, 1);
    issue(0, 0);
    @(posedge mclk);
    end_sim();
  end
endmodule // lfa_alu_bench
`default_nettype wire
